// ===== acd_top.sv
// Output FIFO and the ATA command decoder with identify and sector buffer.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module acd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output var  logic             inReady,
    output var  logic             outValid,
    output var  logic [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic [CW-1:0]    slot;
    wire logic        push;
    wire logic        pop;

    // Shift-register organisation keeps the head word in a flip-flop.
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign count_next = CW'(count_reg + CW'(push) - CW'(pop));
    assign slot = pop ? CW'(count_reg - CW'(1)) : count_reg;
    assign outData = mem_reg[0];

    // Flags are registered from the next count so they stay honest.
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_reg <= '0;
            outValid <= 1'b0;
            inReady <= 1'b1;
        end else begin
            count_reg <= count_next;
            outValid <= count_next != '0;
            inReady <= count_next != CW'(DEPTH);
        end
    end

    // Data storage needs no reset; only the count gives it meaning.
    always_ff @(posedge mclk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (push && CW'(i) == slot) begin
                mem_reg[i] <= inData;
            end else if (pop && i < DEPTH - 1) begin
                mem_reg[i] <= mem_reg[i + 1];
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module acd_top (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         cmdValid,
    input  wire logic [7:0]   cmdOpcode,
    input  wire logic [7:0]   cmdFeature,
    input  wire logic [7:0]   cmdCount,
    input  wire logic [31:0]  totalSectors,
    input  wire logic [159:0] serialNumber,
    input  wire logic [63:0]  fwRevision,
    input  wire logic         dinValid,
    input  wire logic [15:0]  dinData,
    input  wire logic         doutReady,
    output var  logic         cmdReady,
    output var  logic         cmdDone,
    output var  logic         cmdError,
    output var  logic [5:0]   cmdProtocol,
    output var  logic         dinReady,
    output var  logic         doutValid,
    output var  logic [15:0]  doutData,
    output var  logic         powerLevel,
    output var  logic         throttle
);
    acd_pkg::acd_state_t state_reg;
    acd_pkg::acd_state_t state_next;
    logic [7:0]  wordIdx_reg;
    logic        srcIdent_reg;
    logic [15:0] secBuf_reg [256];
    wire logic   taken;
    wire logic   lastWord;
    wire logic   pushStep;
    wire logic   loadStep;
    wire logic   fifoInReady;
    wire logic   fifoInValid;
    wire logic   setPower;
    wire logic   powerNext;
    wire logic [5:0]  proto;
    wire logic [15:0] fifoInData;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode and subcommand decode into a one-hot protocol code.
    function automatic logic [5:0] decodeProto(
        input logic [7:0] op,
        input logic [7:0] feat,
        input logic [7:0] cnt
    );
        logic [5:0] p;
        p = acd_pkg::PR_ABORT;
        case (op)
            acd_pkg::OP_DIAG: p = acd_pkg::PR_DIAG;
            acd_pkg::OP_IDENT, acd_pkg::OP_RDBUF, acd_pkg::OP_RDMUL,
            acd_pkg::OP_RDSEC0, acd_pkg::OP_RDSEC1: p = acd_pkg::PR_PIO_IN;
            acd_pkg::OP_WRMUL, acd_pkg::OP_WRSEC0, acd_pkg::OP_WRSEC1, acd_pkg::OP_WRBUF,
            acd_pkg::OP_SC_SETPW, acd_pkg::OP_SC_UNLK, acd_pkg::OP_SC_ERASE,
            acd_pkg::OP_SC_DISPW: p = acd_pkg::PR_PIO_OUT;
            acd_pkg::OP_RDDMA, acd_pkg::OP_WRDMA: p = acd_pkg::PR_DMA;
            acd_pkg::OP_FLUSH, acd_pkg::OP_NOP, acd_pkg::OP_INITP, acd_pkg::OP_SETMUL,
            acd_pkg::OP_VER0, acd_pkg::OP_VER1, acd_pkg::OP_SC_PREP, acd_pkg::OP_SC_FRZ,
            acd_pkg::OP_NATMAX: p = acd_pkg::PR_NONDATA;
            acd_pkg::OP_CHKPM0, acd_pkg::OP_CHKPM1, acd_pkg::OP_IDLE0, acd_pkg::OP_IDLE1,
            acd_pkg::OP_IDLI0, acd_pkg::OP_IDLI1, acd_pkg::OP_SLP0, acd_pkg::OP_SLP1,
            acd_pkg::OP_STBY0, acd_pkg::OP_STBY1, acd_pkg::OP_STBI0,
            acd_pkg::OP_STBI1: p = acd_pkg::PR_NONDATA;
            acd_pkg::OP_SETFEAT: begin
                // Only a level the card really has may be selected.
                if (feat != acd_pkg::FEAT_PWR || cnt == acd_pkg::LVL0 ||
                    (cnt == acd_pkg::LVL1 && acd_pkg::LEVEL1_OK)) begin
                    p = acd_pkg::PR_NONDATA;
                end
            end
            acd_pkg::OP_SMART: begin
                case (feat)
                    acd_pkg::SM_RDATA, acd_pkg::SM_RTHR: p = acd_pkg::PR_PIO_IN;
                    acd_pkg::SM_AUTOSV, acd_pkg::SM_SAVE, acd_pkg::SM_OFFL, acd_pkg::SM_EN,
                    acd_pkg::SM_DIS, acd_pkg::SM_STAT: p = acd_pkg::PR_NONDATA;
                    default: p = acd_pkg::PR_ABORT;
                endcase
            end
            acd_pkg::OP_HPA: begin
                case (feat)
                    acd_pkg::HPA_SETMAX, acd_pkg::HPA_LOCK,
                    acd_pkg::HPA_FRZ: p = acd_pkg::PR_NONDATA;
                    acd_pkg::HPA_SETPW, acd_pkg::HPA_UNLK: p = acd_pkg::PR_PIO_OUT;
                    default: p = acd_pkg::PR_ABORT;
                endcase
            end
            default: p = acd_pkg::PR_ABORT;
        endcase
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Identify data word for a given index; unlisted words read as zero.
    function automatic logic [15:0] identWord(
        input logic [7:0]   idx,
        input logic [31:0]  sec,
        input logic [159:0] sn,
        input logic [63:0]  fw
    );
        logic [15:0] w;
        w = '0;
        if (idx >= acd_pkg::IW_SN_LO && idx <= acd_pkg::IW_SN_HI) begin
            w = sn[16 * (int'(acd_pkg::IW_SN_HI) - int'(idx)) +: 16];
        end else if (idx >= acd_pkg::IW_FW_LO && idx <= acd_pkg::IW_FW_HI) begin
            w = fw[16 * (int'(acd_pkg::IW_FW_HI) - int'(idx)) +: 16];
        end else begin
            case (idx)
                acd_pkg::IW_GENCFG: w = acd_pkg::ID_GENCFG;
                acd_pkg::IW_OBS5: w = acd_pkg::ID_OBS5;
                acd_pkg::IW_SECT_MSW: w = sec[31:16];
                acd_pkg::IW_SECT_LSW: w = sec[15:0];
                acd_pkg::IW_OBS20, acd_pkg::IW_OBS21: w = acd_pkg::ID_OBS20;
                acd_pkg::IW_OBS22: w = acd_pkg::ID_OBS22;
                acd_pkg::IW_MAXMUL: w = acd_pkg::ID_MAXMUL;
                acd_pkg::IW_CAP49: w = acd_pkg::ID_CAP49;
                acd_pkg::IW_CAP50: w = acd_pkg::ID_CAP50;
                acd_pkg::IW_PIOTM: w = acd_pkg::ID_PIOTM;
                acd_pkg::IW_VALID: w = acd_pkg::ID_VALID;
                acd_pkg::IW_CAP_LSW: w = sec[15:0];
                acd_pkg::IW_CAP_MSW: w = sec[31:16];
                acd_pkg::IW_MULSET: w = acd_pkg::ID_MULSET;
                acd_pkg::IW_LBA_LSW: w = sec[15:0];
                acd_pkg::IW_LBA_MSW: w = sec[31:16];
                acd_pkg::IW_MDMA: w = acd_pkg::ID_MDMA;
                acd_pkg::IW_APIO: w = acd_pkg::ID_APIO;
                acd_pkg::IW_DMA_MIN, acd_pkg::IW_DMA_REC, acd_pkg::IW_PIO_MIN,
                acd_pkg::IW_PIO_FC: w = acd_pkg::ID_CYCLE;
                default: w = '0;
            endcase
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Handshake terms and the power-level selection.
    assign taken = cmdValid && cmdReady;
    assign proto = decodeProto(cmdOpcode, cmdFeature, cmdCount);
    assign lastWord = wordIdx_reg == acd_pkg::LAST_WORD;
    assign fifoInValid = state_reg == acd_pkg::ST_STREAM;
    assign pushStep = fifoInValid && fifoInReady;
    assign loadStep = state_reg == acd_pkg::ST_LOAD && dinValid && dinReady;
    assign setPower = taken && cmdOpcode == acd_pkg::OP_SETFEAT &&
                      cmdFeature == acd_pkg::FEAT_PWR && proto != acd_pkg::PR_ABORT;
    assign powerNext = setPower ? cmdCount[0] : powerLevel;
    assign fifoInData = srcIdent_reg ?
        identWord(wordIdx_reg, totalSectors, serialNumber, fwRevision) :
        secBuf_reg[wordIdx_reg];

    // Only identify and the buffer commands move data here; others finish at once.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            acd_pkg::ST_IDLE: begin
                if (taken) begin
                    if (proto == acd_pkg::PR_ABORT) begin
                        state_next = acd_pkg::ST_FINISH;
                    end else if (cmdOpcode == acd_pkg::OP_IDENT ||
                                 cmdOpcode == acd_pkg::OP_RDBUF) begin
                        state_next = acd_pkg::ST_STREAM;
                    end else if (cmdOpcode == acd_pkg::OP_WRBUF) begin
                        state_next = acd_pkg::ST_LOAD;
                    end else begin
                        state_next = acd_pkg::ST_FINISH;
                    end
                end
            end
            acd_pkg::ST_STREAM: begin
                if (pushStep && lastWord) begin
                    state_next = acd_pkg::ST_FINISH;
                end
            end
            acd_pkg::ST_LOAD: begin
                if (loadStep && lastWord) begin
                    state_next = acd_pkg::ST_FINISH;
                end
            end
            acd_pkg::ST_FINISH: state_next = acd_pkg::ST_IDLE;
            default: state_next = acd_pkg::ST_IDLE;
        endcase
    end

    // Control state; every port here is a flip-flop.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= acd_pkg::ST_IDLE;
            cmdReady <= 1'b1;
            cmdDone <= 1'b0;
            cmdError <= 1'b0;
            cmdProtocol <= acd_pkg::PR_NONDATA;
            dinReady <= 1'b0;
            powerLevel <= 1'b0;
            throttle <= 1'b1;
            wordIdx_reg <= '0;
            srcIdent_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmdReady <= state_next == acd_pkg::ST_IDLE;
            cmdDone <= state_reg == acd_pkg::ST_FINISH;
            dinReady <= state_next == acd_pkg::ST_LOAD;
            powerLevel <= powerNext;
            throttle <= !powerNext;
            if (taken) begin
                cmdProtocol <= proto;
                cmdError <= proto == acd_pkg::PR_ABORT;
                srcIdent_reg <= cmdOpcode == acd_pkg::OP_IDENT;
                wordIdx_reg <= '0;
            end else if (pushStep || loadStep) begin
                wordIdx_reg <= wordIdx_reg + 8'h01;
            end
        end
    end

    // Sector buffer holds the last block written by the host.
    always_ff @(posedge mclk) begin
        if (loadStep) begin
            secBuf_reg[wordIdx_reg] <= dinData;
        end
    end

    // The FIFO lets the host stall reads; a full FIFO holds the word counter.
    acd_fifo #(
        .WIDTH (16),
        .DEPTH (16)
    ) u_fifo (
        .mclk     (mclk),
        .rst      (rst),
        .inValid  (fifoInValid),
        .inData   (fifoInData),
        .inReady  (fifoInReady),
        .outValid (doutValid),
        .outData  (doutData),
        .outReady (doutReady)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks on decode, power level and identify contents.
    rst_level_a: assert property (@(posedge mclk) $past(rst) |-> !powerLevel)
        else $error("power level not 0 after reset");
    feat_lvl0_a: assert property (@(posedge mclk) disable iff (rst)
        (taken && !powerLevel && cmdOpcode == acd_pkg::OP_SETFEAT &&
         cmdFeature != acd_pkg::FEAT_PWR) |=> !cmdError ##1 cmdDone)
        else $error("set features refused at level 0");
    throttle_a: assert property (@(posedge mclk) disable iff (rst)
        throttle == !powerLevel)
        else $error("throttle does not follow level 0");
    ident_pio_a: assert property (@(posedge mclk) disable iff (rst)
        (taken && cmdOpcode == acd_pkg::OP_IDENT) |=>
        cmdProtocol == acd_pkg::PR_PIO_IN && state_reg == acd_pkg::ST_STREAM)
        else $error("identify not streamed as pio in");
    dma_read_a: assert property (@(posedge mclk) disable iff (rst)
        (taken && cmdOpcode == acd_pkg::OP_RDDMA) |=> cmdProtocol == acd_pkg::PR_DMA)
        else $error("read dma not decoded as dma");
    verify_nd_a: assert property (@(posedge mclk) disable iff (rst)
        (taken && cmdOpcode == acd_pkg::OP_VER1) |=> cmdProtocol == acd_pkg::PR_NONDATA)
        else $error("verify not decoded as non-data");
    pm_alias_a: assert property (@(posedge mclk) disable iff (rst)
        (taken && cmdOpcode == acd_pkg::OP_SLP1) |=> cmdProtocol == acd_pkg::PR_NONDATA)
        else $error("sleep alias not non-data");
    smart_rd_a: assert property (@(posedge mclk) disable iff (rst)
        (taken && cmdOpcode == acd_pkg::OP_SMART && cmdFeature == acd_pkg::SM_RDATA)
        |=> cmdProtocol == acd_pkg::PR_PIO_IN)
        else $error("smart read data not pio in");
    ident_w47_a: assert property (@(posedge mclk) disable iff (rst)
        (pushStep && srcIdent_reg && wordIdx_reg == acd_pkg::IW_MAXMUL) |->
        fifoInData == acd_pkg::ID_MAXMUL)
        else $error("identify word 47 wrong");
    ident_lba_a: assert property (@(posedge mclk) disable iff (rst)
        (pushStep && srcIdent_reg && wordIdx_reg == acd_pkg::IW_LBA_LSW) |->
        fifoInData == totalSectors[15:0])
        else $error("identify word 60 wrong");
    abort_a: assert property (@(posedge mclk) disable iff (rst)
        (taken && proto == acd_pkg::PR_ABORT) |=>
        cmdError && !dinReady ##1 cmdDone && !fifoInValid)
        else $error("unknown opcode not aborted");
endmodule

`default_nettype wire

// ===== acd_pkg.sv
// Constants, codes and state types for the ATA command decoder and identify block.
// Notes on behaviour
// - Power level 0 selected after every reset.
// - Identify and Set Features always work at level 0.
// - Level 0 or 1 kept; level 0 throttles.
// - ECh identify in, EFh set feature, 90h diag.
// - C8h/CAh DMA; C4h/C5h multiple; C6h non-data.
// - 2xh read in, 3xh write out, 4xh verify.
// - E7h, 00h, 91h are non-data commands.
// - E4h returns sector buffer, E8h loads it.
// - Power commands under two opcodes, all non-data.
// - Security F1h-F6h; F3h and F5h carry no data.
// - SMART through B0h; two reads are PIO in.
// - F8h non-data; F9h subcommands per data need.
// - Total sectors in words 7-8, MSW first.
// - Serial number in words 10-19, right justified.
// - Firmware revision in words 23-26, big endian.
// - Word 47 returns 8001h.
// - Current capacity in words 57-58, LSW first.
// - LBA sector total in words 60-61, LSW first.
// - Word 63 returns 0007h.
// - Word 64 returns 0003h.
// - Words 65-68 return 0078h.
package acd_pkg;
    localparam logic [7:0] OP_DIAG = 8'h90, OP_FLUSH = 8'he7, OP_IDENT = 8'hec,
        OP_INITP = 8'h91, OP_RDDMA = 8'hc8, OP_RDMUL = 8'hc4, OP_RDSEC0 = 8'h20,
        OP_RDSEC1 = 8'h21, OP_VER0 = 8'h40, OP_VER1 = 8'h41, OP_SETFEAT = 8'hef,
        OP_SETMUL = 8'hc6, OP_WRDMA = 8'hca, OP_WRMUL = 8'hc5, OP_WRSEC0 = 8'h30,
        OP_WRSEC1 = 8'h31, OP_NOP = 8'h00, OP_RDBUF = 8'he4, OP_WRBUF = 8'he8;
    localparam logic [7:0] OP_CHKPM0 = 8'he5, OP_CHKPM1 = 8'h98, OP_IDLE0 = 8'he3,
        OP_IDLE1 = 8'h97, OP_IDLI0 = 8'he1, OP_IDLI1 = 8'h95, OP_SLP0 = 8'he6,
        OP_SLP1 = 8'h99, OP_STBY0 = 8'he2, OP_STBY1 = 8'h96, OP_STBI0 = 8'he0,
        OP_STBI1 = 8'h94;
    localparam logic [7:0] OP_SC_SETPW = 8'hf1, OP_SC_UNLK = 8'hf2, OP_SC_PREP = 8'hf3,
        OP_SC_ERASE = 8'hf4, OP_SC_FRZ = 8'hf5, OP_SC_DISPW = 8'hf6;
    localparam logic [7:0] OP_SMART = 8'hb0, OP_NATMAX = 8'hf8, OP_HPA = 8'hf9;
    localparam logic [7:0] SM_RDATA = 8'hd0, SM_RTHR = 8'hd1, SM_AUTOSV = 8'hd2,
        SM_SAVE = 8'hd3, SM_OFFL = 8'hd4, SM_EN = 8'hd8, SM_DIS = 8'hd9, SM_STAT = 8'hda;
    localparam logic [7:0] HPA_SETMAX = 8'h00, HPA_SETPW = 8'h01, HPA_LOCK = 8'h02,
        HPA_UNLK = 8'h03, HPA_FRZ = 8'h04;
    // Set Features subcommand that selects the power level from the count field.
    localparam logic [7:0] FEAT_PWR = 8'h0a;
    localparam logic [7:0] LVL0 = 8'h00, LVL1 = 8'h01;
    localparam logic       LEVEL1_OK = 1'b1;
    // One-hot transfer protocol codes reported per command.
    localparam logic [5:0] PR_NONDATA = 6'h01, PR_PIO_IN = 6'h02, PR_PIO_OUT = 6'h04,
        PR_DMA = 6'h08, PR_DIAG = 6'h10, PR_ABORT = 6'h20;
    // Identify word indices and fixed values.
    localparam logic [7:0] IW_GENCFG = 8'h00, IW_OBS5 = 8'h05, IW_SECT_MSW = 8'h07,
        IW_SECT_LSW = 8'h08, IW_SN_LO = 8'h0a, IW_SN_HI = 8'h13, IW_OBS20 = 8'h14,
        IW_OBS21 = 8'h15, IW_OBS22 = 8'h16, IW_FW_LO = 8'h17, IW_FW_HI = 8'h1a,
        IW_MAXMUL = 8'h2f, IW_CAP49 = 8'h31, IW_CAP50 = 8'h32, IW_PIOTM = 8'h33,
        IW_VALID = 8'h35, IW_CAP_LSW = 8'h39, IW_CAP_MSW = 8'h3a, IW_MULSET = 8'h3b,
        IW_LBA_LSW = 8'h3c, IW_LBA_MSW = 8'h3d, IW_MDMA = 8'h3f, IW_APIO = 8'h40,
        IW_DMA_MIN = 8'h41, IW_DMA_REC = 8'h42, IW_PIO_MIN = 8'h43, IW_PIO_FC = 8'h44;
    localparam logic [15:0] ID_GENCFG = 16'h044a, ID_OBS5 = 16'h0240, ID_OBS20 = 16'h0002,
        ID_OBS22 = 16'h0004, ID_MAXMUL = 16'h8001, ID_CAP49 = 16'h0f00, ID_CAP50 = 16'h4000,
        ID_PIOTM = 16'h0200, ID_VALID = 16'h0007, ID_MULSET = 16'h0100, ID_MDMA = 16'h0007,
        ID_APIO = 16'h0003, ID_CYCLE = 16'h0078;
    localparam logic [7:0] LAST_WORD = 8'hff;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_STREAM = 4'h2,
        ST_LOAD   = 4'h4,
        ST_FINISH = 4'h8
    } acd_state_t;
endpackage

// ===== acd_host_sink.sv
// Host-side data sink that drains the identify and buffer stream with stalls.
`timescale 1ns/1ns
`default_nettype none
module acd_host_sink (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        clr,
    input  wire logic        doutValid,
    input  wire logic [15:0] doutData,
    output var  logic        doutReady
);
    logic [15:0] words [0:255];
    int          n = 0;
    int          cyc = 0;
    initial doutReady = 1'b0;
    // Stall one cycle in four, so the FIFO fills and back-pressure is really used.
    always @(negedge mclk) begin
        cyc <= cyc + 1;
        doutReady <= (cyc % 4) != 0;
    end
    // Store every popped word; the count keeps running past 256 so extra words show up.
    always @(posedge mclk) begin
        if (rst || clr) begin
            n <= 0;
        end else if (doutValid && doutReady) begin
            words[n % 256] <= doutData;
            n <= n + 1;
        end
    end
endmodule
`default_nettype wire

// ===== acd_top_tb_top.sv
// Self-checking testbench for the command decoder, identify data and sector buffer.
`timescale 1ns/1ns
`default_nettype none
module acd_top_tb_top;
    logic         mclk = 1'b0;
    logic         rst = 1'b1;
    logic         cmdValid = 1'b0;
    logic [7:0]   cmdOpcode = 8'h00;
    logic [7:0]   cmdFeature = 8'h00;
    logic [7:0]   cmdCount = 8'h00;
    logic         dinValid = 1'b0;
    logic [15:0]  dinData = 16'h0000;
    logic         clr = 1'b0;
    logic         doutReady, cmdReady, cmdDone, cmdError, dinReady, doutValid;
    logic         powerLevel, throttle;
    logic [5:0]   cmdProtocol;
    logic [15:0]  doutData;
    logic [31:0]  totalSectors = 32'h1234_5678;
    logic [159:0] serialNumber = "      SERIAL12345678";
    logic [63:0]  fwRevision = "REV1.0AB";
    int           nMismatch = 0;
    int           compares = 0;
    int           wrCnt = 0;
    int           cyc = 0;
    logic [23:0]  cmds [$] = '{24'h900010, 24'he70001, 24'h910001, 24'hc80008, 24'hca0008,
        24'hc40002, 24'hc50004, 24'hc60001, 24'h200002, 24'h210002, 24'h300004, 24'h310004,
        24'h400001, 24'h410001, 24'hef0301, 24'h000001, 24'he50001, 24'h980001, 24'he30001,
        24'h970001, 24'he10001, 24'h950001, 24'he60001, 24'h990001, 24'he20001, 24'h960001,
        24'he00001, 24'h940001, 24'hf10004, 24'hf20004, 24'hf30001, 24'hf40004, 24'hf50001,
        24'hf60004, 24'hb0d002, 24'hb0d102, 24'hb0d201, 24'hb0d301, 24'hb0d401, 24'hb0d801,
        24'hb0d901, 24'hb0da01, 24'hb0d520, 24'hf80001, 24'hf90001, 24'hf90104, 24'hf90201,
        24'hf90304, 24'hf90401, 24'hf90520, 24'h010020, 24'hff0020};

    acd_top dut_u (.mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdOpcode(cmdOpcode),
        .cmdFeature(cmdFeature), .cmdCount(cmdCount), .totalSectors(totalSectors),
        .serialNumber(serialNumber), .fwRevision(fwRevision), .dinValid(dinValid),
        .dinData(dinData), .doutReady(doutReady), .cmdReady(cmdReady), .cmdDone(cmdDone),
        .cmdError(cmdError), .cmdProtocol(cmdProtocol), .dinReady(dinReady),
        .doutValid(doutValid), .doutData(doutData), .powerLevel(powerLevel),
        .throttle(throttle));
    acd_host_sink host_u (.mclk(mclk), .rst(rst), .clr(clr), .doutValid(doutValid),
        .doutData(doutData), .doutReady(doutReady));

    initial forever #10 mclk = ~mclk;
    // Host write data: valid drops every third cycle, each word encodes its own index.
    always @(negedge mclk) begin
        cyc <= cyc + 1;
        dinValid <= (cyc % 3) != 0;
        dinData <= {~wrCnt[7:0], wrCnt[7:0]};
    end
    always @(posedge mclk) if (dinValid && dinReady) wrCnt <= wrCnt + 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Shared compare, verdict, reset and command tasks.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            nMismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("Compares %0d, mismatches %0d", compares, nMismatch);
        if (nMismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(negedge mclk);
        rst <= 1'b1;
        repeat (16) @(negedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        check("powerLevel", powerLevel, 0);
        check("throttle", throttle, 1);
    endtask
    // Issue one command once idle, then wait a bounded time for its completion pulse.
    task automatic do_cmd(input logic [7:0] op, input logic [7:0] feat, input logic [7:0] cnt,
                          input logic [5:0] proto);
        int k;
        k = 0;
        while (cmdReady !== 1'b1 && k < 100) begin
            @(negedge mclk);
            k++;
        end
        cmdValid <= 1'b1;
        cmdOpcode <= op;
        cmdFeature <= feat;
        cmdCount <= cnt;
        @(negedge mclk);
        cmdValid <= 1'b0;
        k = 0;
        while (cmdDone !== 1'b1 && k < 2000) begin
            @(negedge mclk);
            k++;
        end
        check("cmdDone", cmdDone, 1);
        check("cmdProtocol", cmdProtocol, proto);
        check("cmdError", cmdError, proto == acd_pkg::PR_ABORT);
    endtask
    // The FIFO may still hold words after completion, so drain with a bound.
    task automatic get_words();
        int k;
        k = 0;
        while (host_u.n < 256 && k < 300) begin
            @(negedge mclk);
            k++;
        end
        repeat (4) @(negedge mclk);
        check("wordCount", host_u.n, 256);
    endtask
    task automatic clear_sink();
        clr <= 1'b1;
        @(negedge mclk);
        clr <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: identify, buffer round trip, opcode table, power levels.
    initial begin
        do_reset();
        clear_sink();
        do_cmd(acd_pkg::OP_IDENT, 8'h00, 8'h00, acd_pkg::PR_PIO_IN);
        get_words();
        check("w7", host_u.words[7], totalSectors[31:16]);
        check("w8", host_u.words[8], totalSectors[15:0]);
        for (int i = 0; i < 10; i++) check("serial", host_u.words[10 + i], serialNumber[159 - 16 * i -: 16]);
        for (int i = 0; i < 4; i++) check("fwrev", host_u.words[23 + i], fwRevision[63 - 16 * i -: 16]);
        check("w47", host_u.words[47], 16'h8001);
        check("w57", host_u.words[57], totalSectors[15:0]);
        check("w58", host_u.words[58], totalSectors[31:16]);
        check("w60", host_u.words[60], totalSectors[15:0]);
        check("w61", host_u.words[61], totalSectors[31:16]);
        check("w63", host_u.words[63], 16'h0007);
        check("w64", host_u.words[64], 16'h0003);
        for (int i = 65; i < 68; i++) check("cycleTime", host_u.words[i], 16'h0078);
        wrCnt <= 0;
        do_cmd(acd_pkg::OP_WRBUF, 8'h00, 8'h00, acd_pkg::PR_PIO_OUT);
        check("wrCnt", wrCnt, 256);
        clear_sink();
        do_cmd(acd_pkg::OP_RDBUF, 8'h00, 8'h00, acd_pkg::PR_PIO_IN);
        get_words();
        for (int i = 0; i < 256; i++) check("buffer", host_u.words[i], {~i[7:0], i[7:0]});
        clear_sink();
        foreach (cmds[j]) do_cmd(cmds[j][23:16], cmds[j][15:8], 8'h00, cmds[j][5:0]);
        check("noData", host_u.n, 0);
        do_cmd(acd_pkg::OP_SETFEAT, acd_pkg::FEAT_PWR, 8'h01, acd_pkg::PR_NONDATA);
        check("powerLevel", powerLevel, 1);
        check("throttle", throttle, 0);
        do_cmd(acd_pkg::OP_SETFEAT, acd_pkg::FEAT_PWR, 8'h02, acd_pkg::PR_ABORT);
        check("powerLevel", powerLevel, 1);
        do_cmd(acd_pkg::OP_SETFEAT, acd_pkg::FEAT_PWR, 8'h00, acd_pkg::PR_NONDATA);
        check("throttle", throttle, 1);
        do_cmd(acd_pkg::OP_SETFEAT, acd_pkg::FEAT_PWR, 8'h01, acd_pkg::PR_NONDATA);
        do_reset();
        conclude();
    end
    // Watchdog: the whole sequence needs well under five thousand cycles.
    initial begin
        repeat (20000) @(posedge mclk);
        nMismatch++;
        conclude();
    end
endmodule
`default_nettype wire
